// ---- verilog/output_driver_gain_mute_regs.v ----
`timescale 1ns/1ps
`default_nettype none
`include "output_driver_map.vh"
module output_driver_gain_mute_regs #(
    parameter STEP_CYCLES = `GAIN_STEP_CYCLES
) (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Register port from the host control interface
    input wire [6:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    output reg [7:0] reg_rdata_q,
    // Left headphone driver controls
    output reg [3:0] left_headphone_driver_gain_q,
    output reg left_headphone_driver_unmute_q,
    // Right headphone driver controls
    output reg [3:0] right_headphone_driver_gain_q,
    output reg right_headphone_driver_unmute_q,
    // Left speaker driver controls
    output reg [1:0] left_speaker_driver_gain_q,
    output reg left_speaker_driver_unmute_q
);
    // Stored control words and the restart pulse that follows each write
    reg [7:0] left_hp_ctrl_q;
    reg [7:0] right_hp_ctrl_q;
    reg [7:0] left_spk_ctrl_q;
    reg left_hp_restart_q;
    reg right_hp_restart_q;
    reg left_spk_restart_q;
    // Gain walkers: target code in, applied code and settled flag out
    wire [3:0] left_hp_target;
    wire [3:0] right_hp_target;
    wire [3:0] left_spk_target;
    wire [3:0] left_hp_applied;
    wire [3:0] right_hp_applied;
    wire [3:0] left_spk_applied;
    wire left_hp_done;
    wire right_hp_done;
    wire left_spk_done;
    // Address decode and the words seen by a read
    wire left_hp_sel;
    wire right_hp_sel;
    wire left_spk_sel;
    wire left_hp_wr;
    wire right_hp_wr;
    wire left_spk_wr;
    wire [7:0] left_hp_status;
    wire [7:0] right_hp_status;
    wire [7:0] left_spk_status;
    reg [7:0] rdata_d;

    // Reserved codes clamp to the top legal step so the stage stays defined
    function [3:0] clamp_hp;
        input [3:0] code;
        begin
            if (code > `HP_GAIN_MAX)
                clamp_hp = `HP_GAIN_MAX;
            else
                clamp_hp = code;
        end
    endfunction

    // Headphone gain field of a stored control word
    function [3:0] hp_gain_field;
        input [7:0] ctrl;
        begin
            hp_gain_field = ctrl[`HP_GAIN_MSB:`HP_GAIN_LSB];
        end
    endfunction

    // Speaker gain field, padded to the walker's width
    function [3:0] spk_gain_field;
        input [7:0] ctrl;
        begin
            spk_gain_field = {2'b00, ctrl[`SPK_GAIN_MSB:`SPK_GAIN_LSB]};
        end
    endfunction

    // Mute control bit of a stored word: 0 keeps the stage muted
    function unmute_of;
        input [7:0] ctrl;
        begin
            unmute_of = ctrl[`UNMUTE_BIT];
        end
    endfunction

    // Status bit 0 is read-only, so it is masked out of every stored word
    function [7:0] masked_word;
        input [7:0] data;
        input [7:0] mask;
        begin
            masked_word = data & mask;
        end
    endfunction

    // Read word: stored bits 7 to 1 with the live settled flag in bit 0
    // The restart pulse masks the flag in the cycle before the walker drops it
    function [7:0] read_word;
        input [7:0] ctrl;
        input settled;
        input restart;
        begin
            read_word = {ctrl[7:1], settled & ~restart};
        end
    endfunction

    // Exact match of the 7-bit register address
    function addr_match;
        input [6:0] addr;
        input [6:0] slot;
        begin
            addr_match = (addr == slot);
        end
    endfunction

    assign left_hp_sel = addr_match(reg_addr, `LEFT_HEADPHONE_DRIVER_CTRL_ADDR);
    assign right_hp_sel = addr_match(reg_addr, `RIGHT_HEADPHONE_DRIVER_CTRL_ADDR);
    assign left_spk_sel = addr_match(reg_addr, `LEFT_SPEAKER_DRIVER_CTRL_ADDR);
    assign left_hp_wr = reg_wr && left_hp_sel;
    assign right_hp_wr = reg_wr && right_hp_sel;
    assign left_spk_wr = reg_wr && left_spk_sel;

    assign left_hp_target = clamp_hp(hp_gain_field(left_hp_ctrl_q));
    assign right_hp_target = clamp_hp(hp_gain_field(right_hp_ctrl_q));
    assign left_spk_target = spk_gain_field(left_spk_ctrl_q);

    // Status words for the read decode
    assign left_hp_status = read_word(left_hp_ctrl_q, left_hp_done, left_hp_restart_q);
    assign right_hp_status = read_word(right_hp_ctrl_q, right_hp_done, right_hp_restart_q);
    assign left_spk_status = read_word(left_spk_ctrl_q, left_spk_done, left_spk_restart_q);

    // Reserved bits are stored as written; the host keeps them at their defined values
    // Left headphone control word and its restart pulse
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            left_hp_ctrl_q <= `HP_RESET_VALUE;
            left_hp_restart_q <= 1'b0;
        end
        else
        begin
            left_hp_restart_q <= left_hp_wr;
            if (left_hp_wr)
            begin
                left_hp_ctrl_q <= masked_word(reg_wdata, `HP_WRITE_MASK);
            end
        end
    end

    // Right headphone control word and its restart pulse
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            right_hp_ctrl_q <= `HP_RESET_VALUE;
            right_hp_restart_q <= 1'b0;
        end
        else
        begin
            right_hp_restart_q <= right_hp_wr;
            if (right_hp_wr)
            begin
                right_hp_ctrl_q <= masked_word(reg_wdata, `HP_WRITE_MASK);
            end
        end
    end

    // Left speaker control word and its restart pulse
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            left_spk_ctrl_q <= `SPK_RESET_VALUE;
            left_spk_restart_q <= 1'b0;
        end
        else
        begin
            left_spk_restart_q <= left_spk_wr;
            if (left_spk_wr)
            begin
                left_spk_ctrl_q <= masked_word(reg_wdata, `SPK_WRITE_MASK);
            end
        end
    end

    // One gain walker per stage steps the applied code toward the target
    // A write restarts the walk even when the code is unchanged
    gain_ramp #(
        .WIDTH(4),
        .STEP_CYCLES(STEP_CYCLES)
    ) u_left_hp_ramp (
        .clk(clk),
        .arst_n(arst_n),
        .target(left_hp_target),
        .restart(left_hp_restart_q),
        .applied_q(left_hp_applied),
        .done_q(left_hp_done)
    );

    gain_ramp #(
        .WIDTH(4),
        .STEP_CYCLES(STEP_CYCLES)
    ) u_right_hp_ramp (
        .clk(clk),
        .arst_n(arst_n),
        .target(right_hp_target),
        .restart(right_hp_restart_q),
        .applied_q(right_hp_applied),
        .done_q(right_hp_done)
    );

    gain_ramp #(
        .WIDTH(4),
        .STEP_CYCLES(STEP_CYCLES)
    ) u_left_spk_ramp (
        .clk(clk),
        .arst_n(arst_n),
        .target(left_spk_target),
        .restart(left_spk_restart_q),
        .applied_q(left_spk_applied),
        .done_q(left_spk_done)
    );

    // Read decode for the three mapped words; everything else reads zero
    always @*
    begin
        rdata_d = 8'h00;
        if (left_hp_sel)
        begin
            rdata_d = left_hp_status;
        end
        else if (right_hp_sel)
        begin
            rdata_d = right_hp_status;
        end
        else if (left_spk_sel)
        begin
            rdata_d = left_spk_status;
        end
    end

    // Read data is captured on the read strobe and held until the next one
    // Reading has no side effect on the settled flags
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata_q <= 8'h00;
        else if (reg_rd)
            reg_rdata_q <= rdata_d;
    end

    // Stage controls leave through flip-flops; gain follows the walker one cycle late
    // Left headphone stage controls
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            left_headphone_driver_gain_q <= `HP_GAIN_RESET;
            left_headphone_driver_unmute_q <= 1'b0;
        end
        else
        begin
            left_headphone_driver_gain_q <= left_hp_applied;
            left_headphone_driver_unmute_q <= unmute_of(left_hp_ctrl_q);
        end
    end

    // Right headphone stage controls
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            right_headphone_driver_gain_q <= `HP_GAIN_RESET;
            right_headphone_driver_unmute_q <= 1'b0;
        end
        else
        begin
            right_headphone_driver_gain_q <= right_hp_applied;
            right_headphone_driver_unmute_q <= unmute_of(right_hp_ctrl_q);
        end
    end

    // Left speaker stage controls
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            left_speaker_driver_gain_q <= `SPK_GAIN_RESET;
            left_speaker_driver_unmute_q <= 1'b0;
        end
        else
        begin
            left_speaker_driver_gain_q <= left_spk_applied[1:0];
            left_speaker_driver_unmute_q <= unmute_of(left_spk_ctrl_q);
        end
    end
endmodule
`default_nettype wire

// ---- verilog/output_driver_map.vh ----
// Summary of operation
// - Left headphone gain bits 6:3 select code in dB, 0 to 9; resets 0000.
// - Left headphone bit 2: 0 mutes (reset), 1 unmutes.
// - Left headphone read-only bit 0 is 1 only when all gains applied.
// - Right headphone gain bits 6:3 select 0 to 9 dB in 1 dB steps; resets 0000.
// - Right headphone bit 2: 0 mutes (reset), 1 plays.
// - Right headphone read-only bit 0 is 1 once all gains in effect.
// - Headphone bit 1 reserved, resets to 1; software writes 1 on right.
// - Speaker gain bits 4:3 select 6, 12, 18 or 24 dB; resets 00.
// - Speaker bit 2: 0 holds class-D muted (reset), 1 unmuted.
// - Speaker read-only bit 0 is 1 once all gains applied.
`ifndef OUTPUT_DRIVER_MAP_VH
`define OUTPUT_DRIVER_MAP_VH
`define LEFT_HEADPHONE_DRIVER_CTRL_ADDR 7'h28
`define RIGHT_HEADPHONE_DRIVER_CTRL_ADDR 7'h29
`define LEFT_SPEAKER_DRIVER_CTRL_ADDR 7'h2a
`define HP_GAIN_MSB 6
`define HP_GAIN_LSB 3
`define SPK_GAIN_MSB 4
`define SPK_GAIN_LSB 3
`define UNMUTE_BIT 2
`define HP_RSVD1_BIT 1
`define APPLIED_BIT 0
`define HP_GAIN_RESET 4'h0
`define HP_GAIN_MAX 4'h9
`define SPK_GAIN_RESET 2'h0
`define HP_RSVD1_RESET 1'h1
`define HP_WRITE_MASK 8'hfe
`define SPK_WRITE_MASK 8'hfe
`define HP_RESET_VALUE 8'h02
`define SPK_RESET_VALUE 8'h00
`define GAIN_STEP_TIME_NS 1000
`define GAIN_STEP_CYCLES ((`GAIN_STEP_TIME_NS + 24) / 25)
`endif

// ---- verilog/gain_ramp.v ----
`timescale 1ns/1ps
`default_nettype none
// Walks the applied gain one code per step toward the programmed target
module gain_ramp #(
    parameter WIDTH = 4,
    parameter STEP_CYCLES = 40
) (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Target from register
    input wire [WIDTH-1:0] target,
    input wire restart,
    // Applied gain and status
    output reg [WIDTH-1:0] applied_q,
    output reg done_q
);
    localparam CW = 16;
    reg [CW-1:0] cnt_q;
    wire step;

    assign step = (cnt_q == 16'h0000);

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            applied_q <= {WIDTH{1'b0}};
            cnt_q <= 16'h0000;
            // Settled flag reads 0 in reset and rises on the first edge after release
            done_q <= 1'b0;
        end
        else
        begin
            if (restart)
            begin
                cnt_q <= STEP_CYCLES[CW-1:0] - 16'h0001;
                done_q <= 1'b0;
            end
            else if (applied_q == target)
            begin
                cnt_q <= 16'h0000;
                done_q <= 1'b1;
            end
            else
            begin
                done_q <= 1'b0;
                if (step)
                begin
                    cnt_q <= STEP_CYCLES[CW-1:0] - 16'h0001;
                    if (applied_q < target)
                        applied_q <= applied_q + {{(WIDTH-1){1'b0}}, 1'b1};
                    else
                        applied_q <= applied_q - {{(WIDTH-1){1'b0}}, 1'b1};
                end
                else
                    cnt_q <= cnt_q - 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/driver_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module driver_model (
    // Driver controls
    input wire logic [3:0] hp_gain,
    input wire logic hp_unmute,
    input wire logic [1:0] spk_gain,
    input wire logic spk_unmute,
    // Gain heard at the load, 0 while muted
    output wire logic [4:0] hp_db,
    output wire logic [4:0] spk_db
);
    assign hp_db = hp_unmute ? {1'b0, hp_gain} : 5'h0;
    assign spk_db = spk_unmute ? 5'h6 + 5'h6 * spk_gain : 5'h0;
endmodule
`default_nettype wire

// ---- bench/gain_regs_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module gain_regs_sva (
    // Clock, reset and register port
    input wire clk,
    input wire arst_n,
    input wire [6:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    input wire [7:0] reg_rdata_q,
    // Driver controls
    input wire [3:0] left_headphone_driver_gain_q,
    input wire left_headphone_driver_unmute_q,
    input wire right_headphone_driver_unmute_q,
    input wire [1:0] left_speaker_driver_gain_q,
    input wire left_speaker_driver_unmute_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_hp_max; left_headphone_driver_gain_q <= 4'h9; endproperty
    a_hp_max: assert property (p_hp_max) else $error("gain over 9");
    property p_l_mute; reg_wr && reg_addr == 7'h28
        |-> ##2 left_headphone_driver_unmute_q == $past(reg_wdata[2], 2); endproperty
    a_l_mute: assert property (p_l_mute) else $error("left mute wrong");
    property p_r_mute; reg_wr && reg_addr == 7'h29
        |-> ##2 right_headphone_driver_unmute_q == $past(reg_wdata[2], 2); endproperty
    a_r_mute: assert property (p_r_mute) else $error("right mute wrong");
    property p_s_mute; reg_wr && reg_addr == 7'h2a
        |-> ##2 left_speaker_driver_unmute_q == $past(reg_wdata[2], 2); endproperty
    a_s_mute: assert property (p_s_mute) else $error("speaker mute wrong");
    property p_l_step; $changed(left_headphone_driver_gain_q) |-> left_headphone_driver_gain_q
        - $past(left_headphone_driver_gain_q) inside {4'h1, 4'hf}; endproperty
    a_l_step: assert property (p_l_step) else $error("left gain jumped");
    property p_s_step; $changed(left_speaker_driver_gain_q) |-> left_speaker_driver_gain_q
        - $past(left_speaker_driver_gain_q) inside {2'h1, 2'h3}; endproperty
    a_s_step: assert property (p_s_step) else $error("speaker gain jumped");
    property p_flag; reg_wr && reg_addr == 7'h28 ##2 reg_rd && reg_addr == 7'h28
        |=> !reg_rdata_q[0]; endproperty
    a_flag: assert property (p_flag) else $error("flag not cleared");
    property p_unmapped; reg_rd && reg_addr > 7'h2a |=> reg_rdata_q == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule
bind output_driver_gain_mute_regs gain_regs_sva u_sva (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .left_headphone_driver_gain_q(left_headphone_driver_gain_q),
    .left_headphone_driver_unmute_q(left_headphone_driver_unmute_q),
    .right_headphone_driver_unmute_q(right_headphone_driver_unmute_q),
    .left_speaker_driver_gain_q(left_speaker_driver_gain_q),
    .left_speaker_driver_unmute_q(left_speaker_driver_unmute_q));
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, arst_n, reg_wr, reg_rd, lu, ru, su;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_q, v;
    logic [3:0] lg, rg;
    logic [1:0] sg;
    logic [4:0] hp_db, spk_db;
    int err_total = 0, num_checks = 0, cyc = 0, i;
    output_driver_gain_mute_regs #(.STEP_CYCLES(2)) u_output_driver_gain_mute_regs (.clk(clk),
        .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .left_headphone_driver_gain_q(lg),
        .left_headphone_driver_unmute_q(lu), .right_headphone_driver_gain_q(rg),
        .right_headphone_driver_unmute_q(ru), .left_speaker_driver_gain_q(sg),
        .left_speaker_driver_unmute_q(su));
    driver_model u_driver_model (.hp_gain(lg), .hp_unmute(lu), .spk_gain(sg), .spk_unmute(su),
        .hp_db(hp_db), .spk_db(spk_db));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_q;
    endtask
    task test_done;
        $display("mismatches %0d comparisons %0d", err_total, num_checks);
        if (err_total == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Cuts a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            test_done;
        end
    end
    initial
    begin
        {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd(7'h28, v); chk("left reset", 8'h03, v);
        rd(7'h29, v); chk("right reset", 8'h03, v);
        rd(7'h2a, v); chk("speaker reset", 8'h01, v);
        wr(7'h28, 8'h4e);
        rd(7'h28, v); chk("left pending", 8'h4e, v);
        wr(7'h29, 8'h2e);
        wr(7'h2a, 8'h1c);
        wr(7'h30, 8'hff);
        rd(7'h30, v); chk("unmapped", 8'h00, v);
        for (i = 0; i < 200 && v !== 8'h4f; i++) rd(7'h28, v);
        chk("left applied", 8'h4f, v);
        rd(7'h29, v); chk("right applied", 8'h2f, v);
        rd(7'h2a, v); chk("speaker applied", 8'h1d, v);
        chk("left db", 8'h09, {3'h0, hp_db});
        chk("right gain", 8'h15, {3'h0, ru, rg});
        chk("speaker db", 8'h18, {3'h0, spk_db});
        wr(7'h28, 8'h0a);
        rd(7'h28, v); chk("left muted db", 8'h00, {3'h0, hp_db});
        test_done;
    end
endmodule
`default_nettype wire
